// ==== pcmc_composer.sv ====
// periodic message composer: four timed slots pack controller variables
// into eight-byte frames and queue them for the network controller
// assumes variables and ready come from logic on the same clock
`timescale 1ns/1ps
`include "pcmc_defines.svh"

module pcmc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic          push;
    logic          pop;

    assign o_in_ready  = (count_ff != CW'(D));
    assign o_out_valid = (count_ff != '0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(D - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(D - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_ff <= count_ff + 1'b1;
                2'b01:   count_ff <= count_ff - 1'b1;
                default: count_ff <= count_ff;
            endcase
        end
    end
endmodule

module pcmc_composer #(
    parameter int P_MS_CYCLES = `PCMC_MS_CYCLES
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic [31:0]      O_RDATA,
    input  wire logic [6:0]  I_NODE_ID,
    input  wire logic [15:0] I_KEY_VOLT_CV,
    input  wire logic [15:0] I_DC_BUS_DV,
    input  wire logic [15:0] I_NODE_CUR_DA,
    input  wire logic [15:0] I_SPEED_KMH10,
    input  wire logic [15:0] I_SPEED_KMH16,
    input  wire logic [15:0] I_SPEED_MPH10,
    input  wire logic [15:0] I_SPEED_MPH16,
    input  wire logic [7:0]  I_SOC_PCT,
    input  wire logic [7:0]  I_FAULT_CODE,
    output logic             O_TX_VALID,
    input  wire logic        I_TX_READY,
    output logic [10:0]      O_TX_ID,
    output logic [63:0]      O_TX_DATA
);
    localparam int NS = `PCMC_SLOTS;

    logic                  role_en_ff;
    logic [10:0]           id_ff     [NS];
    logic                  add_ff    [NS];
    logic [15:0]           rate_ff   [NS];
    logic [63:0]           items_ff  [NS];
    logic [NS-1:0]         reject_ff;
    logic [NS-1:0]         due_ff;
    logic [NS-1:0]         fire;
    logic [NS-1:0]         take;
    logic [NS-1:0]         slot_en;
    logic [31:0]           ms_cnt_ff;
    logic                  ms_tick;
    logic [31:0]           nxt_rdata;

    logic                  is_slot;
    logic [1:0]            w_slot;
    logic [3:0]            w_sub;
    logic                  cfg_ok;
    logic [NS-1:0]         nxt_reject_set;

    pcmc_pkg::pcmc_state_t state_ff;
    logic [63:0]           cur_items_ff;
    logic [10:0]           cur_id_ff;
    logic [63:0]           pay_ff;
    logic [3:0]            pos_ff;
    logic [3:0]            idx_ff;
    pcmc_pkg::pcmc_item_t  cur_code;
    logic [15:0]           item_val;
    logic                  item_word;
    logic                  item_end;
    logic [3:0]            pos_nx;

    logic                  fifo_ready;

    function automatic logic [15:0] abs16(input logic [15:0] v);
        abs16 = v[15] ? 16'(~v + 16'h0001) : v;
    endfunction

    function automatic logic id_ok(input logic [10:0] id);
        logic single;
        single = (id == `PCMC_ID_RSV_A) || (id == `PCMC_ID_RSV_B) ||
                 (id == `PCMC_ID_RSV_C) || (id == `PCMC_ID_RSV_D) ||
                 (id == `PCMC_ID_RSV_E) || (id == `PCMC_ID_RSV_F);
        id_ok  = !single &&
                 !((id >= `PCMC_ID_RNG_LO) && (id <= `PCMC_ID_RNG_HI)) &&
                 (id < `PCMC_ID_TOP);
    endfunction

    // register decode
    assign is_slot = (I_ADDR[7:4] >= 4'h1) && (I_ADDR[7:4] <= 4'h4);
    assign w_slot  = 2'(I_ADDR[7:4] - 4'h1);
    assign w_sub   = I_ADDR[3:0];
    assign cfg_ok  = id_ok(I_WDATA[10:0]) &&
                     (I_WDATA[31:16] >= `PCMC_RATE_MIN_MS);

    always_comb begin
        nxt_reject_set = '0;
        if (I_WR && is_slot && role_en_ff && w_sub == `PCMC_SLOT_CFG &&
            !cfg_ok) begin
            nxt_reject_set[w_slot] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            role_en_ff <= 1'b0;
        end else if (I_WR && I_ADDR == `PCMC_REG_CTRL) begin
            role_en_ff <= I_WDATA[`PCMC_CTRL_ROLE_BIT];
        end
    end

    // a bad write leaves the old settings in place, so a running slot never
    // sees a half-valid configuration
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int s = 0; s < NS; s++) begin
                id_ff[s]    <= `PCMC_ID_RST;
                add_ff[s]   <= 1'b0;
                rate_ff[s]  <= `PCMC_RATE_RST;
                items_ff[s] <= `PCMC_ITEMS_RST;
            end
        end else if (I_WR && is_slot && role_en_ff) begin
            case (w_sub)
                `PCMC_SLOT_CFG: begin
                    if (cfg_ok) begin
                        id_ff[w_slot]   <= I_WDATA[10:0];
                        add_ff[w_slot]  <= I_WDATA[`PCMC_CFG_ADD_BIT];
                        rate_ff[w_slot] <= I_WDATA[31:16];
                    end
                end
                `PCMC_SLOT_ITEMS_LO: items_ff[w_slot][31:0]  <= I_WDATA;
                `PCMC_SLOT_ITEMS_HI: items_ff[w_slot][63:32] <= I_WDATA;
                default: ;
            endcase
        end
    end

    // sticky reject flags: write one to clear, a new reject wins
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            reject_ff <= '0;
        end else begin
            reject_ff <= (I_WR && I_ADDR == `PCMC_REG_STATUS) ?
                         ((reject_ff & ~I_WDATA[3:0]) | nxt_reject_set) :
                         (reject_ff | nxt_reject_set);
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (I_ADDR == `PCMC_REG_CTRL) begin
            nxt_rdata[`PCMC_CTRL_ROLE_BIT] = role_en_ff;
        end else if (I_ADDR == `PCMC_REG_STATUS) begin
            nxt_rdata[15:0] = {due_ff, 2'b00, state_ff, slot_en, reject_ff};
        end else if (is_slot) begin
            case (w_sub)
                `PCMC_SLOT_CFG: nxt_rdata = {rate_ff[w_slot], 4'h0,
                                             add_ff[w_slot], id_ff[w_slot]};
                `PCMC_SLOT_ITEMS_LO: nxt_rdata = items_ff[w_slot][31:0];
                `PCMC_SLOT_ITEMS_HI: nxt_rdata = items_ff[w_slot][63:32];
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RDATA <= 32'h0000_0000;
        end else if (I_RD) begin
            O_RDATA <= nxt_rdata;
        end else begin
            O_RDATA <= 32'h0000_0000;
        end
    end

    // millisecond time base
    assign ms_tick = (ms_cnt_ff == 32'(P_MS_CYCLES - 1));

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ms_cnt_ff <= 32'h0000_0000;
        end else begin
            ms_cnt_ff <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
        end
    end

    // per-slot period timers
    for (genvar s = 0; s < NS; s++) begin : g_slot
        logic [15:0] per_cnt_ff;

        assign slot_en[s] = role_en_ff && (id_ff[s] != 11'h000);
        assign fire[s]    = slot_en[s] && ms_tick &&
                            (per_cnt_ff >= rate_ff[s] - 16'h0001);

        always_ff @(posedge I_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                per_cnt_ff <= 16'h0000;
            end else if (!slot_en[s]) begin
                per_cnt_ff <= 16'h0000;
            end else if (ms_tick) begin
                per_cnt_ff <= fire[s] ? 16'h0000 : per_cnt_ff + 16'h0001;
            end
        end

        // a period that elapses while the slot still waits to be taken merges into
        // the pending one rather than piling up; frames already in the queue still pile up
        always_ff @(posedge I_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                due_ff[s] <= 1'b0;
            end else if (!slot_en[s]) begin
                due_ff[s] <= 1'b0;
            end else begin
                due_ff[s] <= (due_ff[s] & ~take[s]) | fire[s];
            end
        end
    end

    // lowest-numbered due slot is served first
    always_comb begin
        take = '0;
        if (state_ff == pcmc_pkg::PCMC_ST_IDLE) begin
            for (int s = NS - 1; s >= 0; s--) begin
                if (due_ff[s]) begin
                    take = '0;
                    take[s] = 1'b1;
                end
            end
        end
    end

    // item value selection
    assign cur_code = pcmc_pkg::pcmc_item_t'(cur_items_ff[{idx_ff[2:0], 3'b000} +: 5]);

    always_comb begin
        item_val  = {8'h00, `PCMC_FILL_BYTE};
        item_word = 1'b1;
        item_end  = 1'b0;
        unique case (cur_code)
            pcmc_pkg::PCMC_IT_END:      item_end = 1'b1;
            pcmc_pkg::PCMC_IT_EMPTY_B:  item_word = 1'b0;
            pcmc_pkg::PCMC_IT_EMPTY_W:
                item_val = {`PCMC_FILL_BYTE, `PCMC_FILL_BYTE};
            pcmc_pkg::PCMC_IT_KEY_V:    item_val = I_KEY_VOLT_CV;
            pcmc_pkg::PCMC_IT_DC_BUS_V: item_val = I_DC_BUS_DV;
            pcmc_pkg::PCMC_IT_CUR:      item_val = I_NODE_CUR_DA;
            pcmc_pkg::PCMC_IT_CUR_ABS:  item_val = abs16(I_NODE_CUR_DA);
            pcmc_pkg::PCMC_IT_K10:      item_val = I_SPEED_KMH10;
            pcmc_pkg::PCMC_IT_K10_ABS:  item_val = abs16(I_SPEED_KMH10);
            pcmc_pkg::PCMC_IT_K16:      item_val = I_SPEED_KMH16;
            pcmc_pkg::PCMC_IT_K16_ABS:  item_val = abs16(I_SPEED_KMH16);
            pcmc_pkg::PCMC_IT_M10:      item_val = I_SPEED_MPH10;
            pcmc_pkg::PCMC_IT_M10_ABS:  item_val = abs16(I_SPEED_MPH10);
            pcmc_pkg::PCMC_IT_M16:      item_val = I_SPEED_MPH16;
            pcmc_pkg::PCMC_IT_M16_ABS:  item_val = abs16(I_SPEED_MPH16);
            pcmc_pkg::PCMC_IT_SOC: begin
                item_word = 1'b0;
                item_val  = {8'h00, (I_SOC_PCT > `PCMC_SOC_MAX) ?
                             `PCMC_SOC_MAX : I_SOC_PCT};
            end
            pcmc_pkg::PCMC_IT_FAULT: begin
                item_word = 1'b0;
                item_val  = {8'h00, (I_FAULT_CODE > `PCMC_FAULT_MAX) ?
                             `PCMC_FAULT_MAX : I_FAULT_CODE};
            end
            default:                    item_end = 1'b1;
        endcase
    end

    assign pos_nx = pos_ff + 4'h1;

    // composer: one item per cycle, then hand the frame to the queue
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_ff     <= pcmc_pkg::PCMC_ST_IDLE;
            cur_items_ff <= 64'h0000_0000_0000_0000;
            cur_id_ff    <= 11'h000;
            pay_ff       <= 64'h0000_0000_0000_0000;
            pos_ff       <= 4'h0;
            idx_ff       <= 4'h0;
        end else begin
            unique case (state_ff)
                pcmc_pkg::PCMC_ST_IDLE: begin
                    if (|due_ff) begin
                        for (int s = 0; s < NS; s++) begin
                            if (take[s]) begin
                                cur_items_ff <= items_ff[s];
                                cur_id_ff    <= add_ff[s] ?
                                    11'(id_ff[s] + {4'h0, I_NODE_ID}) :
                                    id_ff[s];
                            end
                        end
                        pay_ff   <= {8{`PCMC_FILL_BYTE}};
                        pos_ff   <= 4'h0;
                        idx_ff   <= 4'h0;
                        state_ff <= pcmc_pkg::PCMC_ST_PACK;
                    end
                end
                pcmc_pkg::PCMC_ST_PACK: begin
                    // a word that would spill past byte 7 ends the list
                    if (idx_ff == 4'(`PCMC_ITEMS) || item_end ||
                        pos_ff == 4'(`PCMC_PAYLOAD_BYTES) ||
                        (item_word && pos_ff == 4'h7)) begin
                        state_ff <= pcmc_pkg::PCMC_ST_PUSH;
                    end else if (item_word) begin
                        pay_ff[{pos_ff[2:0], 3'b000} +: 8] <= item_val[7:0];
                        pay_ff[{pos_nx[2:0], 3'b000} +: 8] <=
                            item_val[15:8];
                        pos_ff <= pos_ff + 4'h2;
                        idx_ff <= idx_ff + 4'h1;
                    end else begin
                        pay_ff[{pos_ff[2:0], 3'b000} +: 8] <= item_val[7:0];
                        pos_ff <= pos_nx;
                        idx_ff <= idx_ff + 4'h1;
                    end
                end
                pcmc_pkg::PCMC_ST_PUSH: begin
                    if (fifo_ready) begin
                        state_ff <= pcmc_pkg::PCMC_ST_IDLE;
                    end
                end
                default: state_ff <= pcmc_pkg::PCMC_ST_IDLE;
            endcase
        end
    end

    // the queue feeds the shared network controller, which sends every
    // frame at the one network bit rate
    pcmc_fifo #(
        .W (`PCMC_FIFO_W),
        .D (`PCMC_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_resetn    (I_RESETN),
        .i_in_valid  (state_ff == pcmc_pkg::PCMC_ST_PUSH),
        .o_in_ready  (fifo_ready),
        .i_in_data   ({cur_id_ff, pay_ff}),
        .o_out_valid (O_TX_VALID),
        .i_out_ready (I_TX_READY),
        .o_out_data  ({O_TX_ID, O_TX_DATA})
    );
endmodule

// ==== pcmc_defines.svh ====
// constants of the periodic message composer: offsets, fields, resets, timing
// assumes one 40 MHz clock; included by bare name
`ifndef PCMC_DEFINES_SVH
`define PCMC_DEFINES_SVH

`define PCMC_CLK_PERIOD_NS  25
`define PCMC_MS_NS          1000000
`define PCMC_MS_CYCLES      (`PCMC_MS_NS / `PCMC_CLK_PERIOD_NS)

`define PCMC_SLOTS          4
`define PCMC_PAYLOAD_BYTES  8
`define PCMC_ITEMS          8
`define PCMC_ID_W           11
`define PCMC_FIFO_DEPTH     8
`define PCMC_FIFO_W         75

`define PCMC_REG_CTRL       8'h00
`define PCMC_REG_STATUS     8'h04
`define PCMC_SLOT_CFG       4'h0
`define PCMC_SLOT_ITEMS_LO  4'h4
`define PCMC_SLOT_ITEMS_HI  4'h8

`define PCMC_CTRL_ROLE_BIT  0
`define PCMC_CFG_ADD_BIT    11
`define PCMC_CFG_RATE_LSB   16

`define PCMC_RATE_MIN_MS    16'h0014
`define PCMC_RATE_RST       16'h0064
`define PCMC_ID_RST         11'h000
`define PCMC_ITEMS_RST      64'h0000_0000_0000_0000

`define PCMC_ID_RSV_A       11'h080
`define PCMC_ID_RSV_B       11'h100
`define PCMC_ID_RSV_C       11'h180
`define PCMC_ID_RSV_D       11'h280
`define PCMC_ID_RSV_E       11'h380
`define PCMC_ID_RSV_F       11'h700
`define PCMC_ID_RNG_LO      11'h580
`define PCMC_ID_RNG_HI      11'h67f
`define PCMC_ID_TOP         11'h77f

`define PCMC_SOC_MAX        8'h64
`define PCMC_FAULT_MAX      8'h96
`define PCMC_FILL_BYTE      8'h00

`endif

// ==== pcmc_pkg.sv ====
// types of the periodic message composer
// assumes pcmc_defines.svh for the numeric constants
package pcmc_pkg;

    typedef enum logic [4:0] {
        PCMC_IT_END       = 5'h00,
        PCMC_IT_EMPTY_B   = 5'h01,
        PCMC_IT_EMPTY_W   = 5'h02,
        PCMC_IT_KEY_V     = 5'h03,
        PCMC_IT_DC_BUS_V  = 5'h04,
        PCMC_IT_CUR       = 5'h05,
        PCMC_IT_CUR_ABS   = 5'h06,
        PCMC_IT_K10       = 5'h07,
        PCMC_IT_K10_ABS   = 5'h08,
        PCMC_IT_K16       = 5'h09,
        PCMC_IT_K16_ABS   = 5'h0a,
        PCMC_IT_M10       = 5'h0b,
        PCMC_IT_M10_ABS   = 5'h0c,
        PCMC_IT_M16       = 5'h0d,
        PCMC_IT_M16_ABS   = 5'h0e,
        PCMC_IT_SOC       = 5'h0f,
        PCMC_IT_FAULT     = 5'h10
    } pcmc_item_t;

    typedef enum logic [1:0] {
        PCMC_ST_IDLE = 2'b00,
        PCMC_ST_PACK = 2'b01,
        PCMC_ST_PUSH = 2'b11
    } pcmc_state_t;

endpackage

// ==== pcmc_sink.sv ====
// frame consumer standing in for the network controller
// assumes the composer's frame port on the same clock
`timescale 1ns/1ps
module pcmc_sink (
    input  wire logic        i_clk,
    input  wire logic        i_hold,
    input  wire logic        i_valid,
    input  wire logic [10:0] i_id,
    input  wire logic [63:0] i_data,
    output logic             o_ready
);
    logic [10:0] q_id[$];
    logic [63:0] q_data[$];
    int          q_t[$];
    int          cyc = 0;
    // a busy controller refuses frames, so the composer must hold them
    assign o_ready = !i_hold;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_valid && o_ready) begin
            q_id.push_back(i_id);
            q_data.push_back(i_data);
            q_t.push_back(cyc);
        end
    end
endmodule

// ==== pcmc_composer_sva.sv ====
// assertions over the composer's register and frame ports
// assumes it is bound onto pcmc_composer, one clock domain
`timescale 1ns/1ps
module pcmc_composer_sva #(
    parameter int P_MS_CYCLES = 40000
) (
    input wire logic        I_CLK,
    input wire logic        I_RESETN,
    input wire logic [7:0]  I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic        O_TX_VALID,
    input wire logic        I_TX_READY,
    input wire logic [10:0] O_TX_ID,
    input wire logic [63:0] O_TX_DATA
);
    logic role_ff;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // rejects only count while the role is on, so mirror it here
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            role_ff <= 1'b0;
        end else if (I_WR && I_ADDR == 8'h00) begin
            role_ff <= I_WDATA[0];
        end
    end
    AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 32'h0)
        else $error("read data seen outside a read");
    AST_CTRL_RB: assert property (I_WR && I_ADDR == 8'h00 ##1
        I_RD && I_ADDR == 8'h00 |=> O_RDATA == {31'h0, $past(I_WDATA[0], 2)})
        else $error("role bit reads back wrong");
    AST_TX_HOLD: assert property (
        O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_ID)
        && $stable(O_TX_DATA)) else $error("frame changed while waiting");
    AST_TX_POP: assert property ($fell(O_TX_VALID) |-> $past(I_TX_READY))
        else $error("frame dropped without being taken");
    AST_ID_LIVE: assert property (O_TX_VALID |-> O_TX_ID != 11'h000)
        else $error("frame sent with identifier zero");
    AST_REJ_RATE: assert property (
        role_ff && I_WR && I_ADDR == 8'h10 && I_WDATA[31:16] < 16'h0014
        ##1 I_RD && I_ADDR == 8'h04 |=> O_RDATA[0])
        else $error("short period not flagged");
    AST_REJ_RSV: assert property (
        role_ff && I_WR && I_ADDR == 8'h10 && I_WDATA[10:0] inside {11'h080,
        11'h100, 11'h180, 11'h280, 11'h380, 11'h700} ##1 I_RD
        && I_ADDR == 8'h04 |=> O_RDATA[0]) else $error("reserved id kept");
    AST_REJ_RNG: assert property (
        role_ff && I_WR && I_ADDR == 8'h10 && (I_WDATA[10:0] inside
        {[11'h580:11'h67f]} || I_WDATA[10:0] >= 11'h77f) ##1 I_RD
        && I_ADDR == 8'h04 |=> O_RDATA[0]) else $error("range id kept");
endmodule

bind pcmc_composer pcmc_composer_sva #(.P_MS_CYCLES(P_MS_CYCLES)) u_sva (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_TX_VALID(O_TX_VALID),
    .I_TX_READY(I_TX_READY), .O_TX_ID(O_TX_ID), .O_TX_DATA(O_TX_DATA));

// ==== pcmc_composer_bench.sv ====
// self-checking bench of the periodic message composer
// assumes a 40 MHz clock and a millisecond shortened to 10 cycles
`timescale 1ns/1ps
module pcmc_composer_bench;
    localparam int MS = 10;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        hold = 1'b0;
    logic [31:0] rdata, v, prev;
    logic        tx_valid, tx_ready;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
    logic [6:0]  node = 7'h01;
    logic [15:0] key_v = 16'h8001, bus_v = 16'h0102, cur = 16'hff38;
    logic [15:0] spd [4] = '{16'h1234, 16'hfff0, 16'h0a0b, 16'h8000};
    logic [7:0]  soc = 8'hc8, fault = 8'h2a;
    logic [31:0] cfg_tbl [14] = '{
        32'h0014_0080, 32'h0014_0100, 32'h0014_0180, 32'h0014_0280,
        32'h0014_0380, 32'h0014_0700, 32'h0014_0580, 32'h0014_067f,
        32'h0014_077f, 32'h0014_07ff, 32'h0013_0401,
        32'h0014_057f, 32'h0014_0680, 32'h0014_077e};
    logic [63:0] exp_data [3] = '{64'h00c8_ff38_0102_8001,
        64'h0a0b_0010_fff0_1234, 64'h0000_8000_8000_0a0b};
    int          n_fail = 0;
    int          n_tests = 0;

    pcmc_composer #(.P_MS_CYCLES(MS)) u_dut (
        .I_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_NODE_ID(node),
        .I_KEY_VOLT_CV(key_v), .I_DC_BUS_DV(bus_v), .I_NODE_CUR_DA(cur),
        .I_SPEED_KMH10(spd[0]), .I_SPEED_KMH16(spd[1]),
        .I_SPEED_MPH10(spd[2]), .I_SPEED_MPH16(spd[3]), .I_SOC_PCT(soc),
        .I_FAULT_CODE(fault), .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready),
        .O_TX_ID(tx_id), .O_TX_DATA(tx_data));
    pcmc_sink u_sink (.i_clk(clk), .i_hold(hold), .i_valid(tx_valid),
        .i_id(tx_id), .i_data(tx_data), .o_ready(tx_ready));

    always #12.5 clk = ~clk;

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic flush();
        u_sink.q_id.delete();
        u_sink.q_data.delete();
        u_sink.q_t.delete();
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 600 && u_sink.q_id.size() < n; k++) begin
            @(posedge clk);
        end
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole sequence needs about 1400 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(8'h00, v);
        chk(64'(v), 64'h0);
        rd_reg(8'h10, v);
        chk(64'(v), 64'h0064_0000);
        rd_reg(8'hfc, v);
        chk(64'(v), 64'h0);
        wr_reg(8'h10, 32'h0014_0401);
        rd_reg(8'h10, v);
        chk(64'(v), 64'h0064_0000);
        rd_reg(8'h04, v);
        chk(64'(v), 64'h0);
        wr_reg(8'h00, 32'h1);
        rd_reg(8'h00, v);
        chk(64'(v), 64'h1);
        prev = 32'h0064_0000;
        for (int k = 0; k < 14; k++) begin
            wr_reg(8'h10, cfg_tbl[k]);
            rd_reg(8'h04, v);
            chk(64'(v[0]), 64'(k < 11));
            if (k >= 11) begin
                prev = cfg_tbl[k];
            end
            rd_reg(8'h10, v);
            chk(64'(v), 64'(prev));
            wr_reg(8'h04, 32'h0000_000f);
        end
        wr_reg(8'h10, 32'h0014_0c00);
        wr_reg(8'h14, 32'h1002_0f07);
        repeat (20) @(posedge clk);
        flush();
        wait_frames(2);
        chk(64'(u_sink.q_id[0]), 64'h401);
        chk(u_sink.q_data[0], 64'h0000_2a00_0064_1234);
        chk(64'(u_sink.q_t[1] - u_sink.q_t[0]), 64'(20 * MS));
        wr_reg(8'h10, 32'h0014_0000);
        wr_reg(8'h24, 32'h0605_0403);
        wr_reg(8'h34, 32'h0b0a_0908);
        wr_reg(8'h44, 32'h010e_0d0c);
        wr_reg(8'h48, 32'h0000_0001);
        wr_reg(8'h20, 32'h0014_0201);
        wr_reg(8'h30, 32'h0014_0202);
        wr_reg(8'h40, 32'h0014_0203);
        repeat (20) @(posedge clk);
        flush();
        wait_frames(3);
        hold <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            chk(64'(u_sink.q_id[k]), 64'(11'h201 + k));
            chk(u_sink.q_data[k], exp_data[k]);
        end
        // three periods stalled: eight frames queue, the ninth waits
        repeat (700) @(posedge clk);
        rd_reg(8'h04, v);
        chk(64'(v[9:8]), 64'h3);
        chk(64'(tx_valid), 64'h1);
        flush();
        hold <= 1'b0;
        wait_frames(9);
        for (int k = 0; k < 9; k++) begin
            chk(64'(u_sink.q_id[k]), 64'(11'h201 + k % 3));
        end
        repeat (5) @(posedge clk);
        #1;
        chk(64'(tx_valid), 64'h0);
        wrap_up();
    end
endmodule
